// ### logic/csr_consts.vh
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH
// Register addresses
`define CSR_ADDR_BSF      8'h02
`define CSR_ADDR_PTC      8'h03
`define CSR_ADDR_VTO      8'h04
// I2C target address
`define CSR_I2C_ADDR      7'h6B
// Field positions
`define CSR_BOOST_BIT     7
`define CSR_FULLON_BIT    6
`define CSR_VRECHG_BIT    0
// Reset values
`define CSR_BSF_RST       8'hA2
`define CSR_PTC_RST       8'h22
`define CSR_VTO_RST       8'h58
// Clamp limits
`define CSR_FCC_MAX       6'h32
`define CSR_PTC_MAX       4'hC
`define CSR_CV_MAX        5'h18
`define CSR_CV_SPECIAL    5'h0F
// Input limit threshold code for 700 mA (offset 100 mA, 100 mA step)
`define CSR_IIN_700MA     5'h06
// Timing
`define CSR_CLK_HZ        250000000
`define CSR_WD_UNIT_S     40
`define CSR_TOPOFF_UNIT_S 900
`endif

// ### logic/csr_sync3.v
`timescale 1ns/100ps
module csr_sync3 (
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Data
  input  wire pinIn,
  output reg  pinOut
);
  reg [2:0] stage_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      stage_q <= 3'h7;
      pinOut  <= 1'b1;
    end else begin
      stage_q <= {stage_q[1:0], pinIn};
      // Accept a change only once the two later stages agree
      if (stage_q[2] == stage_q[1])
        pinOut <= stage_q[2];
    end
  end
endmodule

// ### logic/csr_sec_tick.v
`timescale 1ns/100ps
`include "csr_consts.vh"
module csr_sec_tick #(
  parameter CLKS_PER_SEC = `CSR_CLK_HZ
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Tick
  output reg  secTick
);
  reg [31:0] cnt_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      cnt_q   <= 32'h0;
      secTick <= 1'b0;
    end else if (cnt_q >= CLKS_PER_SEC - 1) begin
      cnt_q   <= 32'h0;
      secTick <= 1'b1;
    end else begin
      cnt_q   <= cnt_q + 32'h1;
      secTick <= 1'b0;
    end
  end
endmodule

// ### logic/csr_setpoint_regs.v
// Functional notes
// - Boost limit bit selects 0.5 A (0) or 1.2 A (1), default 1.2 A.
// - Full-on 0 uses high-resistance switch below 700 mA limit; 1 always low.
// - In boost mode the full switch is used, full-on bit ignored.
// - Fast-charge current is six bits, 60 mA per LSB up to 1920 mA MSB.
// - Fast-charge current resets to code 100010 (2040 mA).
// - Fast-charge code zero disables charging.
// - Fast-charge writes above 110010 clamp to 110010.
// - Precharge is four bits, 60 mA offset, reset code 0010.
// - Precharge codes above 1100 clamp to 1100.
// - Termination is four bits, 60 mA offset, reset code 0010.
// - Termination codes above 1100 clamp to 1100.
// - Charge voltage is five bits, 3.856 V offset, 32 mV per LSB.
// - Charge voltage resets to 01011; code 01111 decodes as 4.352 V.
// - Charge voltage writes above 11000 clamp to 11000.
// - Top-off timer 00 off, 01 15 min, 10 30 min, 11 45 min.
// - With top-off off, charging ends as soon as termination holds.
// - All fields reset by command and watchdog; full-on by command only.
// - Host reaches registers as I2C target at address 6BH.
// - Watchdog period disabled, 40 s, 80 s or 160 s; expiry resets fields.
`timescale 1ns/100ps
`include "csr_consts.vh"
module csr_setpoint_regs #(
  parameter CLKS_PER_SEC = `CSR_CLK_HZ
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // I2C pins
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe,
  // Resets and watchdog setup
  input  wire       regResetCmd,
  input  wire [1:0] watchdogSel,
  // Charger status
  input  wire       boostMode,
  input  wire [4:0] input_current_limit,
  input  wire       termMet,
  // Charger control outputs
  output reg        otg_output_current_limit,
  output reg        inputSwitchHighRes,
  output reg  [5:0] fast_charge_current,
  output reg        chargeEnable,
  output reg  [3:0] precharge_current,
  output reg  [3:0] termination_current,
  output reg  [9:0] chargeVoltageMv,
  output reg        chargeDone,
  output reg        watchdogExpired
);
  // ------------------------------------------------------------
  // Pin synchronisers and seconds tick
  // ------------------------------------------------------------
  wire sclS;
  wire sdaS;
  wire secTick;
  csr_sync3 uScl (.clk(clk), .rst_b(rst_b), .pinIn(sclIn), .pinOut(sclS));
  csr_sync3 uSda (.clk(clk), .rst_b(rst_b), .pinIn(sdaIn), .pinOut(sdaS));
  csr_sec_tick #(.CLKS_PER_SEC(CLKS_PER_SEC)) uTick (
    .clk    (clk),
    .rst_b  (rst_b),
    .secTick(secTick)
  );

  // ------------------------------------------------------------
  // I2C target
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WR   = 3'h3;
  localparam ST_WACK = 3'h4;
  localparam ST_RD   = 3'h5;
  localparam ST_RACK = 3'h6;

  reg       sclD_q;
  reg       sdaD_q;
  reg [2:0] st_q;
  reg [2:0] bitCnt_q;
  reg       gotByte_q;
  reg [7:0] shift_q;
  reg       isRead_q;
  reg       havePtr_q;
  reg [7:0] ptr_q;
  reg       wrStb_q;
  reg [7:0] wrData_q;
  reg [7:0] bsf_q;
  reg [7:0] ptc_q;
  reg [7:0] vto_q;
  reg [7:0] rdData;

  wire sclRise = sclS & ~sclD_q;
  wire sclFall = ~sclS & sclD_q;
  wire startC  = sclS & sclD_q & sdaD_q & ~sdaS;
  wire stopC   = sclS & sclD_q & ~sdaD_q & sdaS;

  always @* begin
    case (ptr_q)
      `CSR_ADDR_BSF: rdData = bsf_q;
      `CSR_ADDR_PTC: rdData = ptc_q;
      `CSR_ADDR_VTO: rdData = vto_q;
      default:       rdData = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      sclD_q    <= 1'b1;
      sdaD_q    <= 1'b1;
      st_q      <= ST_IDLE;
      bitCnt_q  <= 3'h0;
      gotByte_q <= 1'b0;
      shift_q   <= 8'h00;
      isRead_q  <= 1'b0;
      havePtr_q <= 1'b0;
      ptr_q     <= 8'h00;
      wrStb_q   <= 1'b0;
      wrData_q  <= 8'h00;
      sdaOut    <= 1'b0;
      sdaOe     <= 1'b0;
    end else begin
      sclD_q  <= sclS;
      sdaD_q  <= sdaS;
      wrStb_q <= 1'b0;
      if (startC) begin
        st_q      <= ST_ADDR;
        bitCnt_q  <= 3'h0;
        gotByte_q <= 1'b0;
        havePtr_q <= 1'b0;
        sdaOe     <= 1'b0;
      end else if (stopC) begin
        st_q  <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          ST_ADDR, ST_WR: begin
            if (sclRise) begin
              shift_q   <= {shift_q[6:0], sdaS};
              bitCnt_q  <= bitCnt_q + 3'h1;
              gotByte_q <= (bitCnt_q == 3'h7);
            end
            if (sclFall && gotByte_q) begin
              gotByte_q <= 1'b0;
              if (st_q == ST_ADDR) begin
                if (shift_q[7:1] == `CSR_I2C_ADDR) begin
                  isRead_q <= shift_q[0];
                  sdaOe    <= 1'b1;
                  st_q     <= ST_AACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                if (!havePtr_q) begin
                  ptr_q     <= shift_q;
                  havePtr_q <= 1'b1;
                end else begin
                  wrData_q <= shift_q;
                  wrStb_q  <= 1'b1;
                  ptr_q    <= ptr_q + 8'h01;
                end
                sdaOe <= 1'b1;
                st_q  <= ST_WACK;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (sclFall) begin
              if (st_q == ST_AACK && isRead_q) begin
                shift_q <= rdData;
                sdaOe   <= ~rdData[7];
                st_q    <= ST_RD;
              end else begin
                sdaOe <= 1'b0;
                st_q  <= ST_WR;
              end
              bitCnt_q <= 3'h0;
            end
          end
          ST_RD: begin
            if (sclFall) begin
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                sdaOe <= 1'b0;
                ptr_q <= ptr_q + 8'h01;
                st_q  <= ST_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaOe   <= ~shift_q[6];
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              isRead_q <= ~sdaS;
            end
            if (sclFall) begin
              if (isRead_q) begin
                shift_q  <= rdData;
                sdaOe    <= ~rdData[7];
                bitCnt_q <= 3'h0;
                st_q     <= ST_RD;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  reg [7:0] wdCnt_q;
  reg [7:0] wdLimit;
  always @* begin
    case (watchdogSel)
      2'h1:    wdLimit = 8'h28;
      2'h2:    wdLimit = 8'h50;
      2'h3:    wdLimit = 8'hA0;
      default: wdLimit = 8'h00;
    endcase
  end

  // Each data byte written by the host, at any address, counts as a watchdog service; a pointer-only write does not
  always @(posedge clk) begin
    if (!rst_b) begin
      wdCnt_q         <= 8'h00;
      watchdogExpired <= 1'b0;
    end else begin
      watchdogExpired <= 1'b0;
      if (wdLimit == 8'h00 || wrStb_q) begin
        wdCnt_q <= 8'h00;
      end else if (secTick) begin
        if (wdCnt_q + 8'h01 >= wdLimit) begin
          wdCnt_q         <= 8'h00;
          watchdogExpired <= 1'b1;
        end else begin
          wdCnt_q <= wdCnt_q + 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Setpoint registers
  // ------------------------------------------------------------
  wire [5:0] wFcc = (wrData_q[5:0] > `CSR_FCC_MAX) ? `CSR_FCC_MAX
                                                   : wrData_q[5:0];
  wire [3:0] wPre = (wrData_q[7:4] > `CSR_PTC_MAX) ? `CSR_PTC_MAX
                                                   : wrData_q[7:4];
  wire [3:0] wTrm = (wrData_q[3:0] > `CSR_PTC_MAX) ? `CSR_PTC_MAX
                                                   : wrData_q[3:0];
  wire [4:0] wCv  = (wrData_q[7:3] > `CSR_CV_MAX) ? `CSR_CV_MAX
                                                  : wrData_q[7:3];

  always @(posedge clk) begin
    if (!rst_b || regResetCmd) begin
      bsf_q <= `CSR_BSF_RST;
      ptc_q <= `CSR_PTC_RST;
      vto_q <= `CSR_VTO_RST;
    end else if (watchdogExpired) begin
      // Full-on bit survives watchdog expiry
      bsf_q <= (`CSR_BSF_RST & 8'hBF) | (bsf_q & 8'h40);
      ptc_q <= `CSR_PTC_RST;
      vto_q <= `CSR_VTO_RST;
    end else if (wrStb_q) begin
      case (ptr_q - 8'h01)
        `CSR_ADDR_BSF: bsf_q <= {wrData_q[7:6], wFcc};
        `CSR_ADDR_PTC: ptc_q <= {wPre, wTrm};
        `CSR_ADDR_VTO: vto_q <= {wCv, wrData_q[2:0]};
        default:       bsf_q <= bsf_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Decoded controls
  // ------------------------------------------------------------
  reg [11:0] topoffCnt_q;
  reg [11:0] topoffLimit;
  always @* begin
    case (vto_q[2:1])
      2'h1:    topoffLimit = 12'h384;
      2'h2:    topoffLimit = 12'h708;
      2'h3:    topoffLimit = 12'hA8C;
      default: topoffLimit = 12'h000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      otg_output_current_limit <= 1'b1;
      inputSwitchHighRes       <= 1'b0;
      fast_charge_current      <= 6'h22;
      chargeEnable             <= 1'b1;
      precharge_current        <= 4'h2;
      termination_current      <= 4'h2;
      chargeVoltageMv          <= 10'h000;
      topoffCnt_q              <= 12'h000;
      chargeDone               <= 1'b0;
    end else begin
      otg_output_current_limit <= bsf_q[`CSR_BOOST_BIT];
      inputSwitchHighRes <= ~boostMode & ~bsf_q[`CSR_FULLON_BIT] &
        (input_current_limit < `CSR_IIN_700MA);
      fast_charge_current <= bsf_q[5:0];
      chargeEnable        <= (bsf_q[5:0] != 6'h00);
      precharge_current   <= ptc_q[7:4];
      termination_current <= ptc_q[3:0];
      // Millivolts above 3856 mV
      if (vto_q[7:3] == `CSR_CV_SPECIAL)
        chargeVoltageMv <= 10'h1F0;
      else
        chargeVoltageMv <= {vto_q[7:3], 5'h00};
      if (!termMet) begin
        topoffCnt_q <= 12'h000;
        chargeDone  <= 1'b0;
      end else if (topoffLimit == 12'h000) begin
        chargeDone <= 1'b1;
      end else if (secTick && !chargeDone) begin
        if (topoffCnt_q + 12'h001 >= topoffLimit)
          chargeDone <= 1'b1;
        topoffCnt_q <= topoffCnt_q + 12'h001;
      end
    end
  end
endmodule

// ### bench/csr_host_model.sv
`timescale 1ns/100ps
module csr_host_model (
  // Clock
  input  wire clk,
  // Serial bus
  input  wire sdaOe,
  output reg  scl,
  output wire sda
);
  reg hostLow = 1'b0;
  reg acked = 1'b0;
  reg a;
  initial scl = 1'b1;
  // Pull-up: released line reads high, never the last driven value
  assign sda = !(hostLow || sdaOe);
  // One bus phase: SDA set while SCL low, sampled mid-high
  task ph(input l0, input l1, input s4, output s);
    begin
      repeat (10) @(posedge clk);
      hostLow <= l0;
      repeat (10) @(posedge clk);
      scl <= 1'b1;
      repeat (10) @(posedge clk);
      s = sda;
      hostLow <= l1;
      repeat (10) @(posedge clk);
      scl <= s4;
    end
  endtask
  // MSB first, then the ninth clock for the acknowledge
  task byteCyc(input [7:0] v, output [7:0] r, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        ph(!v[i], !v[i], 1'b0, r[i]);
      ph(1'b0, 1'b0, 1'b0, ack);
      ack = !ack;
    end
  endtask
  task wrAt(input [6:0] ad, input [7:0] p, input [7:0] d);
    reg [7:0] r;
    begin
      ph(1'b0, 1'b1, 1'b0, a);
      byteCyc({ad, 1'b0}, r, acked);
      byteCyc(p, r, a);
      byteCyc(d, r, a);
      ph(1'b1, 1'b0, 1'b1, a);
    end
  endtask
  // Repeated start turns the bus round; last byte is not acknowledged
  task rdAt(input [7:0] p, output [7:0] d);
    reg [7:0] r;
    begin
      ph(1'b0, 1'b1, 1'b0, a);
      byteCyc(8'hD6, r, acked);
      byteCyc(p, r, a);
      ph(1'b0, 1'b1, 1'b0, a);
      byteCyc(8'hD7, r, a);
      byteCyc(8'hFF, d, a);
      ph(1'b1, 1'b0, 1'b1, a);
    end
  endtask
endmodule

// ### bench/csr_setpoint_regs_asserts.sv
`timescale 1ns/100ps
module csr_setpoint_regs_asserts (
  // Clock and reset
  input wire       clk,
  input wire       rst_b,
  // Inputs
  input wire       regResetCmd,
  input wire       boostMode,
  input wire [4:0] input_current_limit,
  // Outputs
  input wire       otg_output_current_limit,
  input wire       inputSwitchHighRes,
  input wire [5:0] fast_charge_current,
  input wire       chargeEnable,
  input wire [3:0] precharge_current,
  input wire [3:0] termination_current,
  input wire [9:0] chargeVoltageMv,
  input wire       watchdogExpired
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_fcc_clamp: assert property (fast_charge_current <= 6'h32)
    else $error("fast charge code above limit");
  a_pre_clamp: assert property (precharge_current <= 4'hC)
    else $error("precharge code above limit");
  a_term_clamp: assert property (termination_current <= 4'hC)
    else $error("termination code above limit");
  a_cv_code: assert property (chargeVoltageMv <= 10'h300 &&
    (chargeVoltageMv[4:0] == 5'h00 || chargeVoltageMv == 10'h1F0))
    else $error("charge voltage off grid");
  a_chg_enable: assert property ($stable(fast_charge_current) [*3]
    |-> chargeEnable == (fast_charge_current != 6'h00))
    else $error("charge enable wrong");
  a_boost_full: assert property (boostMode [*3] |-> !inputSwitchHighRes)
    else $error("high resistance in boost");
  a_high_limit: assert property ((input_current_limit >= 5'h06) [*3]
    |-> !inputSwitchHighRes)
    else $error("high resistance at high limit");
  a_reset_dflt: assert property (@(posedge clk) disable iff (1'b0)
    !rst_b |=> otg_output_current_limit && fast_charge_current == 6'h22
    && precharge_current == 4'h2 && termination_current == 4'h2)
    else $error("reset defaults wrong");
  a_cmd_restore: assert property (regResetCmd [*4] |->
    fast_charge_current == 6'h22 && chargeVoltageMv == 10'h160)
    else $error("command reset incomplete");
  a_wd_pulse: assert property (watchdogExpired |=> !watchdogExpired)
    else $error("watchdog pulse too long");
endmodule
bind csr_setpoint_regs csr_setpoint_regs_asserts csr_setpoint_regs_asserts_i (
  .clk, .rst_b, .regResetCmd, .boostMode, .input_current_limit,
  .otg_output_current_limit, .inputSwitchHighRes, .fast_charge_current,
  .chargeEnable, .precharge_current, .termination_current, .chargeVoltageMv,
  .watchdogExpired);

// ### bench/csr_setpoint_regs_tb.sv
`timescale 1ns/100ps
module csr_setpoint_regs_tb;
  reg        clk = 1'b0;
  reg        rst_b = 1'b0;
  reg        regResetCmd = 1'b0;
  reg  [1:0] watchdogSel = 2'h0;
  reg        boostMode = 1'b0;
  reg  [4:0] input_current_limit = 5'h00;
  reg        termMet = 1'b0;
  wire       sclIn, sdaIn, sdaOut, sdaOe, chargeEnable, chargeDone;
  wire       otg_output_current_limit, inputSwitchHighRes, watchdogExpired;
  wire [5:0] fast_charge_current;
  wire [3:0] precharge_current, termination_current;
  wire [9:0] chargeVoltageMv;
  integer    num_errors = 0;
  integer    n_compared = 0;
  integer    seed = 32'h887716B0;
  integer    m [2:4];
  integer    i, n;
  reg  [7:0] rd;
  reg  [4:0] c;
  always #2 clk = !clk;
  // Ten clocks a second keeps timer scenarios short
  csr_setpoint_regs #(.CLKS_PER_SEC(10)) csr_setpoint_regs_i (.clk, .rst_b,
    .sclIn, .sdaIn, .sdaOut, .sdaOe, .regResetCmd, .watchdogSel, .boostMode,
    .input_current_limit, .termMet, .otg_output_current_limit,
    .inputSwitchHighRes, .fast_charge_current, .chargeEnable,
    .precharge_current, .termination_current, .chargeVoltageMv, .chargeDone,
    .watchdogExpired);
  csr_host_model csr_host_model_i (.clk, .sdaOe, .scl(sclIn), .sda(sdaIn));
  // ------
  // Tasks
  // ------
  task chk(input [79:0] nm, input [15:0] s, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("FAIL %0s expected %0h seen %0h", nm, e, s);
      end
    end
  endtask
  function [3:0] cl4(input [3:0] v);
    cl4 = (v > 4'hC) ? 4'hC : v;
  endfunction
  task dflt;
    begin
      m[2] = 8'hA2;
      m[3] = 8'h22;
      m[4] = 8'h58;
    end
  endtask
  task wr(input [7:0] p, input [7:0] d);
    begin
      csr_host_model_i.wrAt(7'h6B, p, d);
      chk("ack", csr_host_model_i.acked, 1'b1);
      if (p == 8'h02)
        m[2] = {d[7:6], (d[5:0] > 6'h32) ? 6'h32 : d[5:0]};
      if (p == 8'h03)
        m[3] = {cl4(d[7:4]), cl4(d[3:0])};
      if (p == 8'h04)
        m[4] = {(d[7:3] > 5'h18) ? 5'h18 : d[7:3], d[2:0]};
      repeat (4) @(posedge clk);
    end
  endtask
  task rdChk(input [7:0] p);
    begin
      csr_host_model_i.rdAt(p, rd);
      chk("readback", rd, (p > 8'h01 && p < 8'h05) ? m[p] : 0);
    end
  endtask
  task outs;
    begin
      c = m[4] >> 3;
      chk("sdaout", sdaOut, 1'b0);
      chk("otg", otg_output_current_limit, m[2] >> 7);
      chk("hires", inputSwitchHighRes, !boostMode && !m[2][6]
        && input_current_limit < 5'h06);
      chk("fcc", fast_charge_current, m[2] & 63);
      chk("chgen", chargeEnable, (m[2] & 63) != 0);
      chk("pre", precharge_current, m[3] >> 4);
      chk("term", termination_current, m[3] & 15);
      chk("cv", chargeVoltageMv, (c == 5'h0F) ? 16'h1F0 : {c, 5'h00});
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    #400000;
    num_errors = num_errors + 1;
    finish_test;
  end
  initial begin
    dflt;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    outs;
    for (i = 2; i <= 5; i = i + 1)
      rdChk(i);
    $display("reset test done");
    for (i = 0; i < 12; i = i + 1) begin
      case (i)
        0: n = 16'h023F;
        1: n = 16'h0200;
        2: n = 16'h03FF;
        3: n = 16'h04F8;
        4: n = 16'h0478;
        5: n = 16'h02C1;
        default: n = (($random(seed) & 255) % 3 + 2) * 256
          + ($random(seed) & 255);
      endcase
      @(posedge clk);
      boostMode <= $random(seed);
      input_current_limit <= $random(seed);
      wr(n >> 8, n);
      outs;
      rdChk(n >> 8);
    end
    $display("write test done");
    csr_host_model_i.wrAt(7'h6A, 8'h02, 8'h00);
    chk("nack", csr_host_model_i.acked, 1'b0);
    outs;
    wr(8'h02, 8'h40);
    regResetCmd <= 1'b1;
    repeat (4) @(posedge clk);
    regResetCmd <= 1'b0;
    dflt;
    repeat (4) @(posedge clk);
    outs;
    wr(8'h02, 8'h55);
    wr(8'h03, 8'h31);
    watchdogSel <= 2'h1;
    n = 0;
    while (watchdogExpired !== 1'b1 && n < 600) begin
      @(posedge clk);
      n = n + 1;
    end
    chk("wdtime", n > 380 && n < 420, 1'b1);
    watchdogSel <= 2'h0;
    m[2] = 8'hA2 | (m[2] & 8'h40);
    m[3] = 8'h22;
    m[4] = 8'h58;
    repeat (4) @(posedge clk);
    outs;
    rdChk(8'h02);
    watchdogSel <= 2'h3;
    n = 0;
    while (watchdogExpired !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n = n + 1;
    end
    chk("wd160", n > 1580 && n < 1620, 1'b1);
    watchdogSel <= 2'h0;
    $display("reset source test done");
    // 15 minutes is 9000 clocks at ten a second
    wr(8'h04, 8'h5A);
    termMet <= 1'b1;
    repeat (8900) @(posedge clk);
    chk("topoff", chargeDone, 1'b0);
    repeat (200) @(posedge clk);
    chk("topoff", chargeDone, 1'b1);
    termMet <= 1'b0;
    wr(8'h04, 8'h58);
    chk("nodelay", chargeDone, 1'b0);
    termMet <= 1'b1;
    repeat (20) @(posedge clk);
    chk("nodelay", chargeDone, 1'b1);
    $display("top-off test done");
    finish_test;
  end
endmodule
